// file: include/cfw_pkg.sv
// Purpose: constants and types for the configuration write handler
// Assumes: one request byte per strobe, frame end flagged by the line receiver
// Notes:   offsets are byte positions within a received request frame
// =====================================================================
// Summary of operation
// - function code 0x15 means write one integer or float value
// - configuration writes go to nonvolatile store, override writes to volatile
// - digital configuration items carry integer data, chosen by tag number
// - tags 0x01-0x7d are float; 0x80-0xd7 and 0xff are integer
// - field order address, code, count, type, file, register, count, data, crc
// - a good write is answered by echoing the request
// - infrared frames get three 0xc0 bytes before and one 0xff after
// - reference type must be 0x06
// - only file number 3, the value register, is accepted
// - tag 0x7d computer setpoint is an unlimited volatile override
// - exactly one parameter per write request
// - float write uses register count 0002 and four data bytes msb first
// - register count 0001 for integer, 0002 for float
// - integers sixteen bits high byte first, floats ieee 32-bit
package cfw_pkg;
  // =================================================================
  // field values
  localparam logic [7:0]  FC_WRITE      = 8'h15;
  localparam logic [7:0]  BC_FLOAT      = 8'h0b;
  localparam logic [7:0]  BC_INT        = 8'h09;
  localparam logic [7:0]  REF_TYPE      = 8'h06;
  localparam logic [15:0] FILE_VALUE    = 16'h0003;
  localparam logic [15:0] CNT_INT       = 16'h0001;
  localparam logic [15:0] CNT_FLOAT     = 16'h0002;
  localparam logic [7:0]  TAG_FLOAT_LO  = 8'h01;
  localparam logic [7:0]  TAG_FLOAT_HI  = 8'h7d;
  localparam logic [7:0]  TAG_INT_LO    = 8'h80;
  localparam logic [7:0]  TAG_INT_HI    = 8'hd7;
  localparam logic [7:0]  TAG_INT_XTRA  = 8'hff;
  localparam logic [7:0]  TAG_OVR_SP    = 8'h7d;
  localparam logic [7:0]  IR_BOF        = 8'hc0;
  localparam logic [7:0]  IR_EOF        = 8'hff;
  localparam logic [4:0]  IR_BOF_NUM    = 5'h03;
  // =================================================================
  // byte positions and lengths
  localparam int          POS_ADDR      = 0;
  localparam int          POS_FC        = 1;
  localparam int          POS_BC        = 2;
  localparam int          POS_REF       = 3;
  localparam int          POS_FILE      = 4;
  localparam int          POS_REG       = 6;
  localparam int          POS_CNT       = 8;
  localparam int          POS_DATA      = 10;
  localparam logic [4:0]  LEN_FLOAT     = 5'h10;
  localparam logic [4:0]  LEN_INT       = 5'h0e;
  localparam int          BUF_DEPTH     = 17;
  // =================================================================
  // crc and reset values
  localparam logic [15:0] CRC_INIT      = 16'hffff;
  localparam logic [15:0] CRC_POLY      = 16'ha001;
  localparam logic [31:0] OVR_RST       = 32'h0000_0000;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RECV = 2'b01,
    ST_SEND = 2'b11
  } cfw_state_e;

  typedef struct packed {
    logic [7:0]  tag;
    logic        is_float;
    logic [31:0] value;
  } cfw_nvwr_s;
endpackage

// file: hw/cfw_top.sv
// Purpose: write-configuration request interpreter, slave side
// Assumes: byte strobes and frame end come from logic on I_CLK_SYS
// Notes:   half duplex; bytes arriving while answering are dropped
`timescale 1ns/100ps
module cfw_top (
  // clock and reset
  input  wire logic             I_CLK_SYS,
  input  wire logic             I_RST,
  // configuration
  input  wire logic [7:0]       I_SLAVE_ADDR,
  input  wire logic             I_IR_MODE,
  // receive byte stream
  input  wire logic             I_RX_VALID,
  input  wire logic [7:0]       I_RX_DATA,
  input  wire logic             I_RX_END,
  // transmit byte stream
  input  wire logic             I_TX_READY,
  output logic                  O_TX_VALID,
  output logic [7:0]            O_TX_DATA,
  // nonvolatile write port
  output logic                  O_NV_WR,
  output cfw_pkg::cfw_nvwr_s    O_NV_REQ,
  // volatile override and status
  output logic [31:0]           O_OVR_SETPOINT,
  output logic                  O_BUSY
);
  // =================================================================
  // state
  cfw_pkg::cfw_state_e state_ff;
  logic [7:0]          buf_ff [cfw_pkg::BUF_DEPTH];
  logic [4:0]          cnt_ff;
  logic [15:0]         crc_ff;
  logic                ovf_ff;
  logic                ir_ff;
  logic [4:0]          tx_pos_ff;
  logic                tx_valid_ff;
  logic [7:0]          tx_data_ff;
  logic                nv_wr_ff;
  cfw_pkg::cfw_nvwr_s  nv_req_ff;
  logic [31:0]         ovr_ff;
  logic                busy_ff;

  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c ^ {8'h00, d};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ cfw_pkg::CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  // =================================================================
  // request decode
  logic       is_float;
  logic [4:0] exp_len;
  logic [7:0] tag;
  logic       tag_float;
  logic       tag_int;
  logic       frame_ok;
  logic       rx_take;
  logic       rx_skip;

  assign is_float  = (buf_ff[cfw_pkg::POS_BC] == cfw_pkg::BC_FLOAT);
  // length is known once the byte count is in; the float length bounds the crc window
  assign exp_len   = (cnt_ff > 5'h02 && !is_float) ? cfw_pkg::LEN_INT : cfw_pkg::LEN_FLOAT;
  assign tag       = buf_ff[cfw_pkg::POS_REG+1];
  assign tag_float = tag >= cfw_pkg::TAG_FLOAT_LO && tag <= cfw_pkg::TAG_FLOAT_HI;
  assign tag_int   = (tag >= cfw_pkg::TAG_INT_LO && tag <= cfw_pkg::TAG_INT_HI)
                     || tag == cfw_pkg::TAG_INT_XTRA;

  always_comb begin
    frame_ok = !ovf_ff
      && (cnt_ff == (ir_ff ? exp_len + 5'h01 : exp_len))
      && (!ir_ff || buf_ff[exp_len] == cfw_pkg::IR_EOF)
      && crc_ff == 16'h0000
      && buf_ff[cfw_pkg::POS_ADDR] == I_SLAVE_ADDR
      && buf_ff[cfw_pkg::POS_FC] == cfw_pkg::FC_WRITE
      && buf_ff[cfw_pkg::POS_REF] == cfw_pkg::REF_TYPE
      && {buf_ff[cfw_pkg::POS_FILE], buf_ff[cfw_pkg::POS_FILE+1]}
         == cfw_pkg::FILE_VALUE
      && buf_ff[cfw_pkg::POS_REG] == 8'h00;
    if (is_float) begin
      frame_ok = frame_ok && tag_float
        && {buf_ff[cfw_pkg::POS_CNT], buf_ff[cfw_pkg::POS_CNT+1]} == cfw_pkg::CNT_FLOAT;
    end else begin
      frame_ok = frame_ok && tag_int
        && buf_ff[cfw_pkg::POS_BC] == cfw_pkg::BC_INT
        && {buf_ff[cfw_pkg::POS_CNT], buf_ff[cfw_pkg::POS_CNT+1]} == cfw_pkg::CNT_INT;
    end
  end

  // leading begin-of-frame bytes on the infrared port are not part of the request
  assign rx_skip = ir_ff && cnt_ff == 5'h00 && I_RX_DATA == cfw_pkg::IR_BOF;
  assign rx_take = I_RX_VALID && state_ff != cfw_pkg::ST_SEND && !rx_skip;

  // =================================================================
  // sequencing
  logic tx_last;
  assign tx_last = tx_pos_ff == (ir_ff ? exp_len + cfw_pkg::IR_BOF_NUM + 5'h01 : exp_len);

  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      state_ff <= cfw_pkg::ST_IDLE;
      busy_ff  <= 1'b0;
    end else begin
      case (state_ff)
        cfw_pkg::ST_IDLE: begin
          if (rx_take) begin
            state_ff <= cfw_pkg::ST_RECV;
          end
        end
        cfw_pkg::ST_RECV: begin
          if (I_RX_END) begin
            state_ff <= frame_ok ? cfw_pkg::ST_SEND : cfw_pkg::ST_IDLE;
            busy_ff  <= frame_ok;
          end
        end
        cfw_pkg::ST_SEND: begin
          if (tx_last && (!tx_valid_ff || I_TX_READY)) begin
            state_ff <= cfw_pkg::ST_IDLE;
            busy_ff  <= 1'b0;
          end
        end
        default: begin
          state_ff <= cfw_pkg::ST_IDLE;
          busy_ff  <= 1'b0;
        end
      endcase
    end
  end

  // mode is held per frame so a change mid-frame cannot split framing
  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      ir_ff <= 1'b0;
    end else if (state_ff == cfw_pkg::ST_IDLE && !I_RX_VALID) begin
      ir_ff <= I_IR_MODE;
    end
  end

  // =================================================================
  // receive buffer and crc
  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      cnt_ff <= 5'h00;
      crc_ff <= cfw_pkg::CRC_INIT;
      ovf_ff <= 1'b0;
    end else if (state_ff == cfw_pkg::ST_IDLE && !rx_take) begin
      cnt_ff <= 5'h00;
      crc_ff <= cfw_pkg::CRC_INIT;
      ovf_ff <= 1'b0;
    end else if (rx_take && !(state_ff == cfw_pkg::ST_RECV && I_RX_END)) begin
      if (cnt_ff == 5'(cfw_pkg::BUF_DEPTH)) begin
        ovf_ff <= 1'b1;
      end else begin
        cnt_ff <= cnt_ff + 5'h01;
      end
      if (cnt_ff < exp_len) begin
        crc_ff <= crc_byte(crc_ff, I_RX_DATA);
      end
    end
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (rx_take && cnt_ff < 5'(cfw_pkg::BUF_DEPTH)) begin
      buf_ff[cnt_ff] <= I_RX_DATA;
    end
  end

  // =================================================================
  // value writes
  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      nv_wr_ff  <= 1'b0;
      nv_req_ff <= '0;
      ovr_ff    <= cfw_pkg::OVR_RST;
    end else begin
      nv_wr_ff <= 1'b0;
      if (state_ff == cfw_pkg::ST_RECV && I_RX_END && frame_ok) begin
        if (tag == cfw_pkg::TAG_OVR_SP) begin
          // volatile, so no endurance limit applies
          ovr_ff <= {buf_ff[cfw_pkg::POS_DATA], buf_ff[cfw_pkg::POS_DATA+1],
                     buf_ff[cfw_pkg::POS_DATA+2], buf_ff[cfw_pkg::POS_DATA+3]};
        end else begin
          nv_wr_ff           <= 1'b1;
          nv_req_ff.tag      <= tag;
          nv_req_ff.is_float <= is_float;
          nv_req_ff.value    <= is_float
            ? {buf_ff[cfw_pkg::POS_DATA], buf_ff[cfw_pkg::POS_DATA+1],
               buf_ff[cfw_pkg::POS_DATA+2], buf_ff[cfw_pkg::POS_DATA+3]}
            : {16'h0000, buf_ff[cfw_pkg::POS_DATA], buf_ff[cfw_pkg::POS_DATA+1]};
        end
      end
    end
  end

  // =================================================================
  // echo transmitter
  logic [7:0] tx_byte;
  logic [4:0] tx_idx;
  always_comb begin
    tx_idx = ir_ff ? tx_pos_ff - cfw_pkg::IR_BOF_NUM : tx_pos_ff;
    if (ir_ff && tx_pos_ff < cfw_pkg::IR_BOF_NUM) begin
      tx_byte = cfw_pkg::IR_BOF;
    end else if (tx_idx < exp_len) begin
      tx_byte = buf_ff[tx_idx];
    end else begin
      tx_byte = cfw_pkg::IR_EOF;
    end
  end

  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      tx_pos_ff   <= 5'h00;
      tx_valid_ff <= 1'b0;
      tx_data_ff  <= 8'h00;
    end else if (state_ff != cfw_pkg::ST_SEND) begin
      tx_pos_ff   <= 5'h00;
      tx_valid_ff <= 1'b0;
    end else if (!tx_valid_ff || I_TX_READY) begin
      tx_valid_ff <= !tx_last;
      if (!tx_last) begin
        tx_data_ff <= tx_byte;
        tx_pos_ff  <= tx_pos_ff + 5'h01;
      end
    end
  end

  assign O_TX_VALID     = tx_valid_ff;
  assign O_TX_DATA      = tx_data_ff;
  assign O_NV_WR        = nv_wr_ff;
  assign O_NV_REQ       = nv_req_ff;
  assign O_OVR_SETPOINT = ovr_ff;
  assign O_BUSY         = busy_ff;

  // =================================================================
  // checks
  property p_nv_not_ovr;
    @(posedge I_CLK_SYS) disable iff (I_RST)
      O_NV_WR |-> O_NV_REQ.tag != cfw_pkg::TAG_OVR_SP;
  endproperty
  a_nv_not_ovr: assert property (p_nv_not_ovr)
    else $error("override tag went to nv store");

  property p_fc;
    @(posedge I_CLK_SYS) disable iff (I_RST)
      O_NV_WR |-> buf_ff[cfw_pkg::POS_FC] == cfw_pkg::FC_WRITE;
  endproperty
  a_fc: assert property (p_fc)
    else $error("write with wrong function code");

  property p_ref;
    @(posedge I_CLK_SYS) disable iff (I_RST)
      $rose(O_BUSY) |-> buf_ff[cfw_pkg::POS_REF] == 8'h06;
  endproperty
  a_ref: assert property (p_ref)
    else $error("accepted bad reference type");

  property p_file;
    @(posedge I_CLK_SYS) disable iff (I_RST)
      $rose(O_BUSY) |-> buf_ff[cfw_pkg::POS_FILE] == 8'h00
        && buf_ff[cfw_pkg::POS_FILE+1] == 8'h03;
  endproperty
  a_file: assert property (p_file)
    else $error("accepted bad file number");

  property p_float_cnt;
    @(posedge I_CLK_SYS) disable iff (I_RST)
      O_NV_WR && O_NV_REQ.is_float |-> buf_ff[cfw_pkg::POS_BC] == 8'h0b
        && buf_ff[cfw_pkg::POS_CNT+1] == 8'h02 && O_NV_REQ.tag <= 8'h7d;
  endproperty
  a_float_cnt: assert property (p_float_cnt)
    else $error("float write malformed");

  property p_ir_pre;
    @(posedge I_CLK_SYS) disable iff (I_RST)
      $rose(O_TX_VALID) && ir_ff |-> O_TX_DATA == 8'hc0;
  endproperty
  a_ir_pre: assert property (p_ir_pre)
    else $error("infrared echo lacks begin byte");

  property p_echo;
    @(posedge I_CLK_SYS) disable iff (I_RST)
      $rose(O_TX_VALID) && !ir_ff |-> O_TX_DATA == I_SLAVE_ADDR;
  endproperty
  a_echo: assert property (p_echo)
    else $error("echo does not start with address");

  property p_crc;
    @(posedge I_CLK_SYS) disable iff (I_RST)
      $rose(O_BUSY) |-> $past(crc_ff) == 16'h0000;
  endproperty
  a_crc: assert property (p_crc)
    else $error("answered a frame with bad crc");

  property p_ovr;
    @(posedge I_CLK_SYS) disable iff (I_RST)
      O_OVR_SETPOINT != $past(O_OVR_SETPOINT) |-> O_BUSY && !O_NV_WR && tag == 8'h7d;
  endproperty
  a_ovr: assert property (p_ovr)
    else $error("override changed without a setpoint write");
endmodule // cfw_top

// file: testbench/cfw_master_model.sv
// Purpose: remote master model, sends write requests and sinks the echo
// Assumes: one byte per cycle at most, frame end pulsed after line silence
// Notes:   crc is appended here so the bench only chooses the fields
`timescale 1ns/100ps
module cfw_master_model (
  // clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  // bench control
  input  wire logic       i_slow,
  // request stream
  output logic            o_rx_valid,
  output logic [7:0]      o_rx_data,
  output logic            o_rx_end,
  // echo stream
  input  wire logic       i_tx_valid,
  input  wire logic [7:0] i_tx_data,
  output logic            o_tx_ready
);
  logic [7:0] sent_q[$];
  logic [7:0] echo_q[$];
  logic [7:0] stall_ff;
  // =================================================================
  // echo sink, stalls by a pseudo random pattern when slow
  initial begin
    o_rx_valid = 1'h0;
    o_rx_data  = 8'h00;
    o_rx_end   = 1'h0;
  end
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      stall_ff   <= 8'h5b;
      o_tx_ready <= 1'h0;
    end else begin
      stall_ff   <= {stall_ff[6:0], stall_ff[7] ^ stall_ff[5] ^ stall_ff[4] ^ stall_ff[3]};
      o_tx_ready <= i_slow ? stall_ff[0] : 1'h1;
      if (i_tx_valid && o_tx_ready) echo_q.push_back(i_tx_data);
    end
  end
  // =================================================================
  // one request per call; bad flips bit 0 of the appended crc
  task automatic send(input logic [7:0] body[$], input logic ir, input logic bad);
    logic [15:0] crc;
    crc = 16'hffff;
    foreach (body[i]) begin
      crc = crc ^ {8'h00, body[i]};
      for (int b = 0; b < 8; b++) crc = crc[0] ? (crc >> 1) ^ 16'ha001 : crc >> 1;
    end
    crc     = crc ^ {15'h0000, bad};
    sent_q  = {body, crc[7:0], crc[15:8]};
    if (ir) sent_q = {8'hc0, 8'hc0, 8'hc0, sent_q, 8'hff};
    echo_q  = {};
    foreach (sent_q[i]) begin
      @(posedge i_clk);
      o_rx_valid <= 1'h1;
      o_rx_data  <= sent_q[i];
    end
    @(posedge i_clk);
    o_rx_valid <= 1'h0;
    o_rx_data  <= ~o_rx_data;
    @(posedge i_clk);
    o_rx_end   <= 1'h1;
    o_rx_data  <= ~o_rx_data;
    @(posedge i_clk);
    o_rx_end   <= 1'h0;
  endtask
endmodule // cfw_master_model

// file: testbench/testbench.sv
// Purpose: self-checking bench for the configuration write handler
// Assumes: slave address 02, echo drained by the master model
// Notes:   expected results come from the field values chosen here
`timescale 1ns/100ps
module testbench;
  logic        clk;
  logic        rst;
  logic [7:0]  slave_addr;
  logic        ir_mode;
  logic        slow;
  logic        rx_valid, rx_end, tx_ready, tx_valid, nv_wr, busy;
  logic [7:0]  rx_data, tx_data;
  logic [31:0] ovr, seed;
  cfw_pkg::cfw_nvwr_s nv_req;
  int          fails, num_checks;
  logic [7:0]  tags[8] = '{8'h01, 8'h74, 8'h7d, 8'h80, 8'hd7, 8'hff, 8'h7e, 8'he0};
  // =================================================================
  // clock, design and master model
  initial begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end
  cfw_top u_cfw_top (.I_CLK_SYS(clk), .I_RST(rst), .I_SLAVE_ADDR(slave_addr),
    .I_IR_MODE(ir_mode), .I_RX_VALID(rx_valid), .I_RX_DATA(rx_data), .I_RX_END(rx_end),
    .I_TX_READY(tx_ready), .O_TX_VALID(tx_valid), .O_TX_DATA(tx_data), .O_NV_WR(nv_wr),
    .O_NV_REQ(nv_req), .O_OVR_SETPOINT(ovr), .O_BUSY(busy));
  cfw_master_model u_master (.i_clk(clk), .i_rst(rst), .i_slow(slow), .o_rx_valid(rx_valid),
    .o_rx_data(rx_data), .o_rx_end(rx_end), .i_tx_valid(tx_valid), .i_tx_data(tx_data),
    .o_tx_ready(tx_ready));
  // =================================================================
  // helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic tag_ok(input logic [7:0] t, input logic isf);
    return isf ? (t >= 8'h01 && t <= 8'h7d) : ((t >= 8'h80 && t <= 8'hd7) || t == 8'hff);
  endfunction
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic stop_test;
    if (fails == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // one request through the model, then outputs and echo compared
  task automatic run(input logic [7:0] dst, fc, rf, fl, rh, tag, input logic isf, bad, ir,
                     input logic [31:0] v);
    logic [7:0]  body[$];
    logic        good;
    logic [31:0] ovr0;
    int          i;
    body = {dst, fc, isf ? 8'h0b : 8'h09, rf, 8'h00, fl, rh, tag, 8'h00, isf ? 8'h02 : 8'h01};
    if (isf) body = {body, v[31:24], v[23:16]};
    body = {body, v[15:8], v[7:0]};
    good = dst == slave_addr && fc == 8'h15 && rf == 8'h06 && fl == 8'h03 && rh == 8'h00
           && tag_ok(tag, isf) && !bad;
    @(posedge clk);
    ir_mode <= ir;
    repeat (2) @(posedge clk);
    ovr0 = ovr;
    u_master.send(body, ir, bad);
    #1;
    chk(busy, good);
    chk(nv_wr, good && tag != 8'h7d);
    if (good && tag != 8'h7d) chk(nv_req, {tag, isf, isf ? v : {16'h0000, v[15:0]}});
    chk(ovr, (good && tag == 8'h7d) ? v : ovr0);
    for (i = 0; i < 400 && busy !== 1'h0; i++) @(posedge clk);
    chk(busy, 1'h0);
    repeat (2) @(posedge clk);
    chk(u_master.echo_q.size(), good ? u_master.sent_q.size() : 0);
    if (good && u_master.echo_q.size() == u_master.sent_q.size())
      for (int k = 0; k < u_master.sent_q.size(); k++)
        chk(u_master.echo_q[k], u_master.sent_q[k]);
  endtask
  // =================================================================
  // main sequence
  initial begin
    rst        = 1'h1;
    slave_addr = 8'h02;
    ir_mode    = 1'h0;
    slow       = 1'h0;
    seed       = 32'h9528;
    repeat (10) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    #1;
    chk(ovr, cfw_pkg::OVR_RST);
    run(8'h02, 8'h15, 8'h06, 8'h03, 8'h00, 8'h01, 1'h1, 1'h0, 1'h0, 32'h3fc00000);
    for (int n = 0; n < 24; n++) begin
      seed = lfsr(seed);
      slow <= seed[3];
      run(8'h02, 8'h15, 8'h06, 8'h03, 8'h00, tags[n % 8], tags[n % 8] <= 8'h7d ^ seed[7] & seed[9],
          1'h0, seed[5], lfsr(seed));
    end
    slow <= 1'h1;
    run(8'h03, 8'h15, 8'h06, 8'h03, 8'h00, 8'h01, 1'h1, 1'h0, 1'h0, 32'h12345678);
    run(8'h02, 8'h14, 8'h06, 8'h03, 8'h00, 8'h01, 1'h1, 1'h0, 1'h0, 32'h12345678);
    run(8'h02, 8'h15, 8'h07, 8'h03, 8'h00, 8'h01, 1'h1, 1'h0, 1'h1, 32'h12345678);
    run(8'h02, 8'h15, 8'h06, 8'h04, 8'h00, 8'h01, 1'h1, 1'h0, 1'h0, 32'h12345678);
    run(8'h02, 8'h15, 8'h06, 8'h03, 8'h01, 8'h01, 1'h1, 1'h0, 1'h0, 32'h12345678);
    run(8'h02, 8'h15, 8'h06, 8'h03, 8'h00, 8'h80, 1'h1, 1'h0, 1'h0, 32'h12345678);
    run(8'h02, 8'h15, 8'h06, 8'h03, 8'h00, 8'h7d, 1'h0, 1'h0, 1'h0, 32'h0000abcd);
    run(8'h02, 8'h15, 8'h06, 8'h03, 8'h00, 8'h05, 1'h1, 1'h1, 1'h1, 32'h12345678);
    run(8'h02, 8'h15, 8'h06, 8'h03, 8'h00, 8'h7d, 1'h1, 1'h0, 1'h1, 32'h42c80000);
    run(8'h02, 8'h15, 8'h06, 8'h03, 8'h00, 8'hff, 1'h0, 1'h0, 1'h0, 32'h0000fffe);
    stop_test;
  end
endmodule // testbench
